// >>> hdl/uar_map.svh
// Constants of the serial receive block: register map, fields and sampling counts
// ==========================================================================
// Contract
// [RL1] Receive-complete reads one while the FIFO holds unread characters.
// [RL2] Clearing receiver enable flushes the FIFO and clears receive-complete.
// [RL3] Interrupt request is a level while enabled and receive-complete set.
// [RL4] Error flags travel with each character; data read advances head.
// [RL5] Status writes leave error flags alone; error flags raise no interrupt.
// [RL6] Software writes zeros to the three error bit positions.
// [RL7] Frame error is one when the head's first stop bit sampled zero.
// [RL8] Only the first stop bit is checked; stop count is ignored.
// [RL9] Overrun when start seen, FIFO full and shift register still waiting.
// [RL10] Overrun clears when a character moves from shift register to FIFO.
// [RL11] Parity checked only with enable bit; odd select chooses polarity.
// [RL12] Parity error per entry, only if checking was enabled at reception.
// [RL13] Disable is immediate: reception abandoned, pin returns to port use.
// [RL14] Software drains the FIFO by reading data until complete clears.
// [RL15] Oversampling sixteen per bit, eight in double-speed mode.
// [RL16] Falling edge starts detection; samples 8,9,10 or 4,5,6 validate.
// [RL17] Two or more high validation samples reject the start as noise.
// [RL18] Bit phase resynchronises on every valid start bit.
// [RL19] Sample counter has sixteen or eight states per bit.
// [RL20] Each bit decided by two-of-three vote of centre samples.
// [RL21] Next start edge accepted right after the stop bit's last vote sample.
// [RL22] Completed character moves from shift register into the FIFO.
// [RL23] Unused upper data bits read as zero for short characters.
// [RL24] Ninth bit stored with its character and shown for head entry.
// [RL25] Line samples are acted on only on baud tick cycles.
`ifndef UAR_MAP_SVH
`define UAR_MAP_SVH
// ==========================================================================
// Register offsets (byte addresses)
`define UAR_OFS_DATA      8'h00
`define UAR_OFS_STATUS_A  8'h04
`define UAR_OFS_CTRL_B    8'h08
`define UAR_OFS_CTRL_C    8'h0c
// Status A fields
`define UAR_SA_PE         2
`define UAR_SA_OVR        3
`define UAR_SA_FE         4
`define UAR_SA_DSPD       1
`define UAR_SA_RXC        7
// Control B fields
`define UAR_CB_RX9        1
`define UAR_CB_RXEN       4
`define UAR_CB_RXCIE      7
// Control C fields
`define UAR_CC_SZ_LO      1
`define UAR_CC_STOP2      3
`define UAR_CC_PODD       4
`define UAR_CC_PEN        5
// Reset value of char size field: 8 bits
`define UAR_SZ_RESET      3'h3
`define UAR_SZ_NINE       3'h7
// Sampling
`define UAR_SMP_NORM      5'h10
`define UAR_SMP_DBL       5'h08
`define UAR_VOTE_NORM     5'h08
`define UAR_VOTE_DBL      5'h04
`define UAR_FIFO_DEPTH    2
`endif

// >>> hdl/uar_pkg.sv
// Types of the serial receive block
package uar_pkg;
  // ==========================================================================
  // Receive state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_BITS
  } uar_state_e;

  // One FIFO entry
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       fe;
    logic       ovr;
    logic       pe;
  } uar_entry_s;
endpackage : uar_pkg

// >>> hdl/uar_rx.sv
// Asynchronous serial receiver with two-entry FIFO and Wishbone registers
`timescale 1ns/10ps
`include "uar_map.svh"
module uar_rx (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial line
  input  wire logic        sample_tick_i,
  input  wire logic        rxd_i,
  output logic             rx_pin_override_o,
  // Interrupt
  output logic             rx_complete_irq_o
);
  // ==========================================================================
  // Registers
  logic       rx_enable;
  logic       rx_complete_irq_enable;
  logic       double_speed_select;
  logic       parity_enable_bit;
  logic       parity_odd_select;
  logic       stop_bit_count_select;
  logic [2:0] char_size;

  logic req;
  logic rd_data;
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_data = req && !wb_we_i && wb_adr_i == `UAR_OFS_DATA;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Error flag positions are never written here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_enable              <= 1'b0;
      rx_complete_irq_enable <= 1'b0;
      double_speed_select    <= 1'b0;
      parity_enable_bit      <= 1'b0;
      parity_odd_select      <= 1'b0;
      stop_bit_count_select  <= 1'b0;
      char_size              <= `UAR_SZ_RESET;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `UAR_OFS_STATUS_A: begin
          double_speed_select <= wb_dat_i[`UAR_SA_DSPD]; // RL5
        end
        `UAR_OFS_CTRL_B: begin
          rx_enable              <= wb_dat_i[`UAR_CB_RXEN];
          rx_complete_irq_enable <= wb_dat_i[`UAR_CB_RXCIE];
          char_size[2]           <= wb_dat_i[2];
        end
        `UAR_OFS_CTRL_C: begin
          char_size[1:0]        <= wb_dat_i[2:1];
          stop_bit_count_select <= wb_dat_i[`UAR_CC_STOP2];
          parity_odd_select     <= wb_dat_i[`UAR_CC_PODD];
          parity_enable_bit     <= wb_dat_i[`UAR_CC_PEN];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // FIFO
  uar_pkg::uar_entry_s fifo [`UAR_FIFO_DEPTH];
  logic       rd_ptr;
  logic       wr_ptr;
  logic [1:0] count;
  logic       push;
  logic       pop;
  uar_pkg::uar_entry_s push_entry;
  uar_pkg::uar_entry_s head;
  logic       rx_complete_flag;

  assign head             = fifo[rd_ptr];
  assign rx_complete_flag = count != 2'h0; // RL1
  assign pop              = rd_data && rx_complete_flag; // RL4

  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_enable) begin
      rd_ptr <= 1'b0; // RL2
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        fifo[wr_ptr] <= push_entry;
        wr_ptr       <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  // ==========================================================================
  // Read data
  logic [7:0] data_mask;
  always_comb begin
    case (char_size)
      3'h0:    data_mask = 8'h1f;
      3'h1:    data_mask = 8'h3f;
      3'h2:    data_mask = 8'h7f;
      default: data_mask = 8'hff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= 32'h0;
      case (wb_adr_i)
        `UAR_OFS_DATA: begin
          wb_dat_o[7:0] <= rx_complete_flag ? (head.data & data_mask) : 8'h00; // RL23
        end
        `UAR_OFS_STATUS_A: begin
          wb_dat_o[`UAR_SA_RXC]  <= rx_complete_flag; // RL1
          wb_dat_o[`UAR_SA_FE]   <= rx_complete_flag && head.fe; // RL7
          wb_dat_o[`UAR_SA_OVR]  <= rx_complete_flag && head.ovr;
          wb_dat_o[`UAR_SA_PE]   <= rx_complete_flag && head.pe; // RL12
          wb_dat_o[`UAR_SA_DSPD] <= double_speed_select;
        end
        `UAR_OFS_CTRL_B: begin
          wb_dat_o[`UAR_CB_RXCIE] <= rx_complete_irq_enable;
          wb_dat_o[`UAR_CB_RXEN]  <= rx_enable;
          wb_dat_o[2]             <= char_size[2];
          wb_dat_o[`UAR_CB_RX9]   <= rx_complete_flag && head.ninth; // RL24
        end
        `UAR_OFS_CTRL_C: begin
          wb_dat_o[2:1]              <= char_size[1:0];
          wb_dat_o[`UAR_CC_STOP2]    <= stop_bit_count_select;
          wb_dat_o[`UAR_CC_PODD]     <= parity_odd_select;
          wb_dat_o[`UAR_CC_PEN]      <= parity_enable_bit;
        end
        default: begin
        end
      endcase
    end
  end

  // Level request; error flags play no part
  assign rx_complete_irq_o = rx_complete_irq_enable && rx_complete_flag; // RL3 RL5
  assign rx_pin_override_o = rx_enable; // RL13

  // ==========================================================================
  // Receive engine
  uar_pkg::uar_state_e state;
  logic [4:0] smp;
  logic [3:0] bit_idx;
  logic [1:0] votes;
  logic [8:0] shreg;
  logic       line_prev;
  logic       held;
  uar_pkg::uar_entry_s held_entry;
  logic       ovr_pend;
  logic [4:0] per_bit;
  logic [4:0] vote_first;
  logic [3:0] data_bits;
  logic [3:0] frame_bits;
  logic       vote_now;
  logic       vote_last;
  // Parity bit kept apart so a nine-bit character is not overwritten
  logic       par_rx;

  assign per_bit    = double_speed_select ? `UAR_SMP_DBL : `UAR_SMP_NORM; // RL15 RL19
  assign vote_first = double_speed_select ? `UAR_VOTE_DBL : `UAR_VOTE_NORM; // RL16
  assign data_bits  = (char_size == `UAR_SZ_NINE) ? 4'h9 : 4'({2'b0, char_size[1:0]} + 4'h5);
  assign frame_bits = 4'(data_bits + {3'b0, parity_enable_bit}); // RL8
  // Third vote is the live sample, so a bit is decided on its last vote sample
  assign vote_now   = (votes[0] & votes[1]) | (votes[0] & rxd_i) | (votes[1] & rxd_i); // RL20
  assign vote_last  = smp == 5'(vote_first + 5'h2);

  logic [8:0] data_only;
  logic       par_calc;
  always_comb begin
    data_only = shreg >> 4'(4'h9 - data_bits);
    par_calc  = ^data_only ^ parity_odd_select; // RL11
  end

  // Completed frame waits in held until FIFO has room
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_enable) begin
      state     <= uar_pkg::ST_IDLE; // RL13
      smp       <= 5'h0;
      bit_idx   <= 4'h0;
      votes     <= 2'h0;
      par_rx    <= 1'b0;
      shreg     <= 9'h0;
      line_prev <= 1'b1;
      held      <= 1'b0;
      held_entry <= '0;
      ovr_pend  <= 1'b0;
    end else begin
      if (push) begin
        held     <= 1'b0;
        ovr_pend <= 1'b0; // RL10
      end
      if (sample_tick_i) begin // RL25
        line_prev <= rxd_i;
        case (state)
          uar_pkg::ST_IDLE: begin
            if (line_prev && !rxd_i) begin // RL16 RL21
              state <= uar_pkg::ST_START;
              smp   <= 5'h2;
              if (held && count == 2'h2) begin
                ovr_pend <= 1'b1; // RL9
              end
            end
          end
          uar_pkg::ST_START: begin
            smp <= 5'(smp + 5'h1);
            if (smp == vote_first) begin
              votes[0] <= rxd_i;
            end
            if (smp == 5'(vote_first + 5'h1)) begin
              votes[1] <= rxd_i;
            end
            if (vote_last && vote_now) begin
              state <= uar_pkg::ST_IDLE; // RL17
            end
            if (smp == per_bit) begin
              state   <= uar_pkg::ST_BITS;
              smp     <= 5'h1; // RL18
              bit_idx <= 4'h0;
            end
          end
          uar_pkg::ST_BITS: begin
            smp <= (smp == per_bit) ? 5'h1 : 5'(smp + 5'h1);
            if (smp == vote_first) begin
              votes[0] <= rxd_i;
            end
            if (smp == 5'(vote_first + 5'h1)) begin
              votes[1] <= rxd_i;
            end
            if (vote_last) begin
              if (bit_idx == frame_bits) begin
                // Idle from the next tick: an early start edge is seen at once
                state               <= uar_pkg::ST_IDLE; // RL21
                held                <= 1'b1; // RL22
                held_entry.data     <= data_only[7:0];
                held_entry.ninth    <= data_only[8];
                held_entry.fe       <= !vote_now; // RL7 RL8
                held_entry.ovr      <= ovr_pend;
                held_entry.pe       <= parity_enable_bit && (par_calc != par_rx); // RL12
              end else begin
                bit_idx <= 4'(bit_idx + 4'h1);
                if (bit_idx < data_bits) begin
                  shreg <= {vote_now, shreg[8:1]};
                end else begin
                  par_rx <= vote_now;
                end
              end
            end
          end
          default: begin
            state <= uar_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign push       = held && (count != 2'h2 || pop);
  assign push_entry = held_entry;

  // ==========================================================================
  // Assertions
  // Flush takes one edge after the enable falls
  a_flush_on_disable: // RL2
    assert property (@(posedge clk_i) disable iff (rst_i)
      !rx_enable |=> !rx_complete_flag)
    else $error("receive FIFO not flushed after disable");

  // Request stays up while nothing is read and the enable stays set
  a_irq_level_holds: // RL3
    assert property (@(posedge clk_i) disable iff (rst_i)
      rx_complete_irq_o && !pop && rx_enable |=>
        rx_complete_flag && (rx_complete_irq_o || !rx_complete_irq_enable))
    else $error("receive interrupt request dropped while flag set");

  a_fifo_bound: // RL4 RL9
    assert property (@(posedge clk_i) disable iff (rst_i)
      count <= 2'h2)
    else $error("receive FIFO count above two");

  a_push_counts: // RL22
    assert property (@(posedge clk_i) disable iff (rst_i)
      push && !pop && rx_enable |=> count == 2'($past(count) + 2'h1))
    else $error("completed character did not enter the FIFO");

  a_disable_aborts: // RL13
    assert property (@(posedge clk_i) disable iff (rst_i)
      !rx_enable |=> state == uar_pkg::ST_IDLE && !held)
    else $error("reception not abandoned on disable");

  // Engine only moves on oversample ticks
  a_tick_only: // RL25
    assert property (@(posedge clk_i) disable iff (rst_i)
      !sample_tick_i && rx_enable |=> $stable(state) && $stable(smp))
    else $error("receive engine moved without a sample tick");

  a_start_detect: // RL16 RL18
    assert property (@(posedge clk_i) disable iff (rst_i)
      rx_enable && sample_tick_i && state == uar_pkg::ST_IDLE && line_prev && !rxd_i
        |=> state == uar_pkg::ST_START && smp == 5'h2)
    else $error("falling edge did not start detection");

  a_noise_reject: // RL17
    assert property (@(posedge clk_i) disable iff (rst_i)
      rx_enable && sample_tick_i && state == uar_pkg::ST_START && vote_last && vote_now
        |=> state == uar_pkg::ST_IDLE)
    else $error("noisy start bit was not rejected");

  a_ack_single: // RL4
    assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
endmodule : uar_rx

// >>> bench/uar_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/10ps
module uar_tx_model (
  // Clock, reset and oversample tick
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  // Frame request, bit zero first
  input  wire logic        go_i,
  input  wire logic [12:0] frame_i,
  input  wire logic [3:0]  len_i,
  input  wire logic [4:0]  spb_i,
  // Line
  output logic             busy_o,
  output logic             rxd_o
);
  logic [12:0] sh;
  logic [3:0]  left;
  logic [4:0]  cnt;

  // Idle line rests high
  assign rxd_o = busy_o ? sh[0] : 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      sh <= '1;
      left <= '0;
      cnt <= '0;
    end else if (go_i) begin
      busy_o <= 1'b1;
      sh <= frame_i;
      left <= len_i;
      cnt <= '0;
    end else if (busy_o && tick_i) begin
      cnt <= (cnt == spb_i - 5'h01) ? 5'h00 : cnt + 5'h01;
      if (cnt == spb_i - 5'h01) begin
        sh <= sh >> 1;
        left <= left - 4'h1;
        busy_o <= (left != 4'h1);
      end
    end
  end
endmodule : uar_tx_model

// >>> bench/tb.sv
// Self-checking bench of the serial receiver over Wishbone
`timescale 1ns/10ps
`include "uar_map.svh"
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("Error at %0t: got %h, expected %h", $time, got, exp); \
  end \
end
module tb;
  // ==========================================================================
  // Signals
  logic        clk_i, rst_i, cyc, stb, we, ack, tick, go, busy, txd, glitch;
  logic        pin_ovr, irq;
  logic [1:0]  div;
  logic [7:0]  adr;
  logic [3:0]  len;
  logic [4:0]  spb;
  logic [12:0] frame;
  logic [31:0] wdat, rdat, rv;
  int          miscompares, num_checks;
  logic [7:0]  cfg [5] = '{8'h26, 8'h26, 8'h36, 8'h36, 8'h06};
  logic [2:0]  pm [5] = '{3'h2, 3'h6, 3'h3, 3'h7, 3'h4};
  logic [4:0]  pe = 5'b01010;

  uar_rx i_uar_rx (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_tick_i(tick), .rxd_i(txd & ~glitch), .rx_pin_override_o(pin_ovr),
    .rx_complete_irq_o(irq));
  uar_tx_model i_uar_tx_model (
    .clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .go_i(go), .frame_i(frame),
    .len_i(len), .spb_i(spb), .busy_o(busy), .rxd_o(txd));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Tick every fourth clock keeps frames short
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    tick <= (div == 2'h3);
  end

  // ==========================================================================
  // Tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (n >= 64) miscompares++;
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic st(input logic [3:0] e);
    wb(1'b0, `UAR_OFS_STATUS_A, 32'h0);
    `CHK({rv[7], rv[4:2]}, e)
  endtask : st
  task automatic rdd(input logic [8:0] e);
    wb(1'b0, `UAR_OFS_DATA, 32'h0);
    `CHK(rv[7:0], e[7:0])
  endtask : rdd
  task automatic fin();
    int n;
    n = 0;
    while (busy && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) miscompares++;
    repeat (48) @(posedge clk_i);
  endtask : fin
  // Pattern {bad, parity on, odd}; w waits for the frame to end
  task automatic send(input logic [8:0] d, input int nb, input logic [2:0] p,
                      input logic stp, input logic w);
    logic [12:0] f;
    int          k;
    f = '1;
    f[0] = 1'b0;
    for (k = 0; k < nb; k++) f[k + 1] = d[k];
    k = nb + 1;
    if (p[1]) begin
      f[k] = p[0] ^ p[2] ^ (^(d & ((9'h1 << nb) - 9'h1)));
      k++;
    end
    f[k] = stp;
    frame <= f;
    len <= 4'(k + 1);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    if (w) fin();
  endtask : send
  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    {rst_i, cyc, stb, we, go, glitch, div, tick} = 9'h100;
    {adr, wdat, len, frame, spb} = {44'h0, 13'h1fff, 5'h10};
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({pin_ovr, irq}, 2'b00)
    wb(1'b1, `UAR_OFS_CTRL_B, 32'h90);
    `CHK(pin_ovr, 1'b1)
    wb(1'b1, `UAR_OFS_CTRL_C, 32'h0e);
    send(9'h0a5, 8, 3'h0, 1'b1, 1'b1);
    `CHK(irq, 1'b1)
    send(9'h03c, 8, 3'h0, 1'b0, 1'b1);
    st(4'h8);
    rdd(9'h0a5);
    st(4'hc);
    wb(1'b1, `UAR_OFS_STATUS_A, 32'h0);
    st(4'hc);
    rdd(9'h03c);
    st(4'h0);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, `UAR_OFS_CTRL_C, {24'h0, cfg[i]});
      send(9'h0b1 + 9'(i), 8, pm[i], 1'b1, 1'b1);
      st({3'h4, pe[i]});
      rdd(9'h0b1 + 9'(i));
    end
    for (int i = 1; i < 5; i++) send(9'(9'h011 * i), 8, 3'h0, 1'b1, 1'b1);
    st(4'h8);
    rdd(9'h011);
    st(4'h8);
    rdd(9'h022);
    st(4'ha);
    for (int i = 0; i < 4 && rv[7]; i++) begin
      wb(1'b0, `UAR_OFS_DATA, 32'h0);
      wb(1'b0, `UAR_OFS_STATUS_A, 32'h0);
    end
    `CHK(rv[7], 1'b0)
    send(9'h055, 8, 3'h0, 1'b1, 1'b1);
    st(4'h8);
    rdd(9'h055);
    send(9'h066, 8, 3'h0, 1'b1, 1'b1);
    send(9'h077, 8, 3'h0, 1'b1, 1'b1);
    wb(1'b1, `UAR_OFS_CTRL_B, 32'h80);
    `CHK({pin_ovr, irq}, 2'b00)
    wb(1'b1, `UAR_OFS_CTRL_B, 32'h90);
    st(4'h0);
    send(9'h0ff, 8, 3'h0, 1'b1, 1'b0);
    repeat (200) @(posedge clk_i);
    wb(1'b1, `UAR_OFS_CTRL_B, 32'h80);
    wb(1'b1, `UAR_OFS_CTRL_B, 32'h90);
    fin();
    st(4'h0);
    glitch <= 1'b1;
    repeat (12) @(posedge clk_i);
    glitch <= 1'b0;
    repeat (200) @(posedge clk_i);
    st(4'h0);
    send(9'h05a, 8, 3'h0, 1'b1, 1'b1);
    rdd(9'h05a);
    wb(1'b1, `UAR_OFS_STATUS_A, 32'h02);
    spb <= 5'h08;
    send(9'h0c3, 8, 3'h0, 1'b1, 1'b1);
    rdd(9'h0c3);
    wb(1'b1, `UAR_OFS_STATUS_A, 32'h0);
    spb <= 5'h10;
    wb(1'b1, `UAR_OFS_CTRL_C, 32'h0);
    send(9'h015, 5, 3'h0, 1'b1, 1'b1);
    rdd(9'h015);
    wb(1'b1, `UAR_OFS_CTRL_B, 32'h94);
    wb(1'b1, `UAR_OFS_CTRL_C, 32'h06);
    send(9'h1a5, 9, 3'h0, 1'b1, 1'b1);
    wb(1'b0, `UAR_OFS_CTRL_B, 32'h0);
    `CHK(rv[1], 1'b1)
    rdd(9'h1a5);
    give_verdict();
  end
endmodule : tb
